// >>> pwm_out_pkg.sv
package pwm_out_pkg;

    // Register indices; the byte address is the index times REG_BYTES
    localparam int REG_BYTES = 32'h4;
    localparam int IDX_SEL = 32'h12;
    localparam int IDX_RSVD = 32'h13;
    localparam int IDX_ACT = 32'h14;
    localparam int IDX_INTEN = 32'h15;
    localparam int IDX_FLG = 32'h16;
    localparam int IDX_CLR = 32'h17;
    localparam int IDX_FRC = 32'h18;
    localparam int IDX_CHOP = 32'h1e;
    localparam int IDX_UNLOCK = 32'h1f;

    // Register width and reset value
    localparam int REG_W = 16;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Fault select layout
    localparam int N_FAULT = 6;
    localparam int CBC_SEL_LSB = 0;
    localparam int SINGLE_TRIP_SEL_LSB = 8;

    // Trip action layout
    localparam int ACT_A_LSB = 0;
    localparam int ACT_B_LSB = 2;

    // Flag, clear, force and enable bit positions
    localparam int FLG_INT = 0;
    localparam int FLG_CBC = 1;
    localparam int FLG_OST = 2;
    localparam int UNLOCK_BIT = 0;

    // Chopper control layout
    localparam int CHP_EN_BIT = 0;
    localparam int CHP_WIDTH_LSB = 1;
    localparam int CHP_WIDTH_W = 4;
    localparam int CHP_FREQ_LSB = 5;
    localparam int CHP_FREQ_W = 3;
    localparam int CHP_DUTY_LSB = 8;
    localparam int CHP_DUTY_W = 3;

    // Chopper timing
    localparam int FIRST_PULSE_UNIT = 8;
    localparam int CARRIER_STEPS = 8;
    localparam int SHOT_W = 8;
    localparam logic [2:0] DUTY_TOP = 3'h7;
    localparam logic [15:0] TB_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        ACT_HIZ = 2'h0,
        ACT_HIGH = 2'h1,
        ACT_LOW = 2'h2,
        ACT_KEEP = 2'h3
    } trip_act_e;

endpackage

// >>> stage_if.sv
`timescale 1ns/100ps
interface stage_if;
    logic [1:0] pwm_raw;
    logic [1:0] chopped;
    logic enable;
    logic [3:0] width;
    logic [2:0] freq;
    logic [2:0] duty;
    logic trip_active;
    logic [1:0][1:0] act;
    logic [1:0] out;
    logic [1:0] oe;

    modport chopper (input pwm_raw, enable, width, freq, duty, output chopped);
    modport forcer (input chopped, trip_active, act, output out, oe);
    modport top (output pwm_raw, enable, width, freq, duty, trip_active, act,
                 input chopped, out, oe);
endinterface

// >>> pwm_chopper.sv
`timescale 1ns/100ps
module pwm_chopper (
    input wire logic pclk,
    input wire logic presetn,
    stage_if.chopper st
);
    localparam int STEP_W = $clog2(pwm_out_pkg::CARRIER_STEPS);

    logic [2:0] pre_reg;
    logic [STEP_W-1:0] step_reg;
    logic [2:0] on_steps;
    logic carrier;
    logic [1:0] prev_reg;

    // Carrier prescaler from the system clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 3'h0;
        end else if (!st.enable || pre_reg == st.freq) begin
            pre_reg <= 3'h0;
        end else begin
            pre_reg <= pre_reg + 3'h1;
        end
    end

    // Carrier step counter, one carrier period per wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_reg <= '0;
        end else if (!st.enable) begin
            step_reg <= '0;
        end else if (pre_reg == st.freq) begin
            step_reg <= step_reg + STEP_W'(1);
        end
    end

    // Sustaining duty in eighths, top code clamps at seven eighths
    assign on_steps = (st.duty == pwm_out_pkg::DUTY_TOP) ? pwm_out_pkg::DUTY_TOP
                                                           : st.duty + 3'h1;
    assign carrier = step_reg < on_steps;

    // Input level history for first-pulse start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 2'h0;
        end else begin
            prev_reg <= st.pwm_raw;
        end
    end

    // First pulse and carrier gating per channel
    for (genvar i = 0; i < 2; i++) begin : g_chan
        logic [pwm_out_pkg::SHOT_W-1:0] shot_reg;
        logic rise;
        logic shot_on;
        assign rise = st.pwm_raw[i] & ~prev_reg[i];
        assign shot_on = rise | (shot_reg != '0);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                shot_reg <= '0;
            end else if (!st.enable || !st.pwm_raw[i]) begin
                shot_reg <= '0;
            end else if (rise) begin
                shot_reg <= pwm_out_pkg::SHOT_W'((int'(st.width) + 1)
                            * pwm_out_pkg::FIRST_PULSE_UNIT - 1);
            end else if (shot_reg != '0) begin
                shot_reg <= shot_reg - pwm_out_pkg::SHOT_W'(1);
            end
        end
        // Wide first pulse, then carrier; disabled stage passes through
        assign st.chopped[i] = st.enable ? (st.pwm_raw[i] & (shot_on | carrier))
                                         : st.pwm_raw[i];
    end
endmodule

// >>> trip_force.sv
`timescale 1ns/100ps
module trip_force (
    stage_if.forcer st
);
    // Output override per pin, purely combinational so it works clockless
    for (genvar i = 0; i < 2; i++) begin : g_pin
        assign st.out[i] = !st.trip_active ? st.chopped[i] :
                           (st.act[i] == pwm_out_pkg::ACT_HIGH) ? 1'b1 :
                           (st.act[i] == pwm_out_pkg::ACT_KEEP) ? st.chopped[i] :
                           1'b0;
        assign st.oe[i] = !(st.trip_active && st.act[i] == pwm_out_pkg::ACT_HIZ);
    end
endmodule

// >>> pwm_chopper_and_trip_zone.sv
// Function
// - Carrier derives from system clock; frequency and duty set in chopper control.
// - Chopping starts with a wide first pulse before sustaining pulses.
// - First pulse lasts eight clocks times width field plus one.
// - Sustaining pulses use seven duty ratios, 12.5% to 87.5%.
// - With carrier disabled the PWM inputs pass through unchanged.
// - Six active-low fault inputs; a low level signals a trip.
// - Each fault input selectable as ignored, cycle trip or single trip.
// - One clock of low level on a selected input registers a trip.
// - Output forcing responds to fault inputs without needing the clock.
// - Cycle trip forces outputs at once, sets its flag, may interrupt.
// - Cycle trip releases at counter zero if the input is gone.
// - Cycle flag stays set until software clears it.
// - Clearing the cycle flag while trip persists sets it again.
// - Single trip forces outputs at once, sets its flag, may interrupt.
// - Single trip persists until software writes its clear bit.
// - Trip action chosen separately for both outputs among four choices.
// - Action code: 0 high-impedance, 1 high, 2 low, 3 no change.
// - Software force register trips exactly like an input; here it forces outputs only from the clock edge that sets the trip latch.
// - Trip registers ignore writes unless protected writes are enabled.
// - With nothing selected or forced, outputs pass through untouched.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module pwm_chopper_and_trip_zone #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pwm_in_a,
    input wire logic pwm_in_b,
    input wire logic [5:0] fault_input_n,
    input wire logic [15:0] time_base_counter,
    output logic pwm_output_a,
    output logic pwm_output_a_oe,
    output logic pwm_output_b,
    output logic pwm_output_b_oe,
    output logic fault_interrupt_request
);
    localparam int NF = pwm_out_pkg::N_FAULT;

    stage_if st ();

    logic [15:0] sel_reg;
    logic [15:0] act_reg;
    logic [15:0] inten_reg;
    logic [15:0] chop_reg;
    logic [15:0] unlock_reg;
    logic cbc_latch_reg;
    logic single_trip_latch_reg;
    logic cbc_flag_reg;
    logic int_flag_reg;
    logic irq_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_next;
    logic [15:0] wmask;
    logic [15:0] wbits;
    logic access;
    logic wr;
    logic mapped;
    logic prot_ok;
    logic clr_cbc;
    logic clr_ost;
    logic clr_int;
    logic frc_cbc;
    logic frc_ost;
    logic cbc_live;
    logic single_trip_live;
    logic cbc_event;
    logic single_trip_event;
    logic at_zero;
    logic int_set;

    // Address match for a register index
    function automatic logic hit(input int idx);
        hit = paddr == ADDR_W'(idx * pwm_out_pkg::REG_BYTES);
    endfunction

    // Byte-lane merge of write data into a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old);
        merge = (old & ~wmask) | (pwdata[15:0] & wmask);
    endfunction

    // Bus decode; zero wait states
    assign access = psel & penable;
    assign mapped = hit(pwm_out_pkg::IDX_SEL) | hit(pwm_out_pkg::IDX_RSVD)
                  | hit(pwm_out_pkg::IDX_ACT) | hit(pwm_out_pkg::IDX_INTEN)
                  | hit(pwm_out_pkg::IDX_FLG) | hit(pwm_out_pkg::IDX_CLR)
                  | hit(pwm_out_pkg::IDX_FRC) | hit(pwm_out_pkg::IDX_CHOP)
                  | hit(pwm_out_pkg::IDX_UNLOCK);
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign wr = access & pwrite & mapped;
    assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wbits = pwdata[15:0] & wmask;
    assign prot_ok = unlock_reg[pwm_out_pkg::UNLOCK_BIT];

    // Clear and force strobes, only when unlocked
    assign clr_cbc = wr & prot_ok & hit(pwm_out_pkg::IDX_CLR)
                   & wbits[pwm_out_pkg::FLG_CBC];
    assign clr_ost = wr & prot_ok & hit(pwm_out_pkg::IDX_CLR)
                   & wbits[pwm_out_pkg::FLG_OST];
    assign clr_int = wr & prot_ok & hit(pwm_out_pkg::IDX_CLR)
                   & wbits[pwm_out_pkg::FLG_INT];
    assign frc_cbc = wr & prot_ok & hit(pwm_out_pkg::IDX_FRC)
                   & wbits[pwm_out_pkg::FLG_CBC];
    assign frc_ost = wr & prot_ok & hit(pwm_out_pkg::IDX_FRC)
                   & wbits[pwm_out_pkg::FLG_OST];

    // Selected fault inputs, active low, no clock in this path
    assign cbc_live = |(~fault_input_n & sel_reg[pwm_out_pkg::CBC_SEL_LSB +: NF]);
    assign single_trip_live = |(~fault_input_n & sel_reg[pwm_out_pkg::SINGLE_TRIP_SEL_LSB +: NF]);
    assign cbc_event = cbc_live | frc_cbc;
    assign single_trip_event = single_trip_live | frc_ost;
    assign at_zero = time_base_counter == pwm_out_pkg::TB_ZERO;

    // Configuration registers, trip ones behind the unlock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= pwm_out_pkg::REG_RESET;
            act_reg <= pwm_out_pkg::REG_RESET;
            inten_reg <= pwm_out_pkg::REG_RESET;
        end else if (wr && prot_ok) begin
            if (hit(pwm_out_pkg::IDX_SEL)) begin
                sel_reg <= merge(sel_reg);
            end
            if (hit(pwm_out_pkg::IDX_ACT)) begin
                act_reg <= merge(act_reg);
            end
            if (hit(pwm_out_pkg::IDX_INTEN)) begin
                inten_reg <= merge(inten_reg);
            end
        end
    end

    // Chopper control and write unlock, always writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chop_reg <= pwm_out_pkg::REG_RESET;
            unlock_reg <= pwm_out_pkg::REG_RESET;
        end else if (wr) begin
            if (hit(pwm_out_pkg::IDX_CHOP)) begin
                chop_reg <= merge(chop_reg);
            end
            if (hit(pwm_out_pkg::IDX_UNLOCK)) begin
                unlock_reg <= merge(unlock_reg);
            end
        end
    end

    // Cycle trip latch: set wins, release at counter zero once input gone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cbc_latch_reg <= 1'b0;
        end else if (cbc_event) begin
            cbc_latch_reg <= 1'b1;
        end else if (at_zero) begin
            cbc_latch_reg <= 1'b0;
        end
    end

    // Cycle flag: sticky, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cbc_flag_reg <= 1'b0;
        end else if (cbc_event) begin
            cbc_flag_reg <= 1'b1;
        end else if (clr_cbc) begin
            cbc_flag_reg <= 1'b0;
        end
    end

    // Single trip latch doubles as its flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            single_trip_latch_reg <= 1'b0;
        end else if (single_trip_event) begin
            single_trip_latch_reg <= 1'b1;
        end else if (clr_ost) begin
            single_trip_latch_reg <= 1'b0;
        end
    end

    // Global flag and interrupt pulse
    assign int_set = (~int_flag_reg | clr_int)
                   & ((cbc_event & inten_reg[pwm_out_pkg::FLG_CBC])
                   | (single_trip_event & inten_reg[pwm_out_pkg::FLG_OST]));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_flag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= int_set;
            if (int_set) begin
                int_flag_reg <= 1'b1;
            end else if (clr_int) begin
                int_flag_reg <= 1'b0;
            end
        end
    end
    assign fault_interrupt_request = irq_reg;

    // Read mux; write-only and gap registers read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        if (hit(pwm_out_pkg::IDX_SEL)) begin
            rd_next[15:0] = sel_reg;
        end else if (hit(pwm_out_pkg::IDX_ACT)) begin
            rd_next[15:0] = act_reg;
        end else if (hit(pwm_out_pkg::IDX_INTEN)) begin
            rd_next[15:0] = inten_reg;
        end else if (hit(pwm_out_pkg::IDX_FLG)) begin
            rd_next[pwm_out_pkg::FLG_INT] = int_flag_reg;
            rd_next[pwm_out_pkg::FLG_CBC] = cbc_flag_reg;
            rd_next[pwm_out_pkg::FLG_OST] = single_trip_latch_reg;
        end else if (hit(pwm_out_pkg::IDX_CHOP)) begin
            rd_next[15:0] = chop_reg;
        end else if (hit(pwm_out_pkg::IDX_UNLOCK)) begin
            rd_next[15:0] = unlock_reg;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rd_next;
        end
    end
    assign prdata = prdata_reg;

    // Stage wiring
    assign st.pwm_raw = {pwm_in_b, pwm_in_a};
    assign st.enable = chop_reg[pwm_out_pkg::CHP_EN_BIT];
    assign st.width = chop_reg[pwm_out_pkg::CHP_WIDTH_LSB +: pwm_out_pkg::CHP_WIDTH_W];
    assign st.freq = chop_reg[pwm_out_pkg::CHP_FREQ_LSB +: pwm_out_pkg::CHP_FREQ_W];
    assign st.duty = chop_reg[pwm_out_pkg::CHP_DUTY_LSB +: pwm_out_pkg::CHP_DUTY_W];
    assign st.act[0] = act_reg[pwm_out_pkg::ACT_A_LSB +: 2];
    assign st.act[1] = act_reg[pwm_out_pkg::ACT_B_LSB +: 2];
    // Live inputs join the latches so forcing needs no clock edge
    assign st.trip_active = cbc_latch_reg | single_trip_latch_reg | cbc_live | single_trip_live;

    pwm_chopper u_chop (
        .pclk(pclk),
        .presetn(presetn),
        .st(st)
    );

    trip_force u_force (
        .st(st)
    );

    assign pwm_output_a = st.out[0];
    assign pwm_output_b = st.out[1];
    assign pwm_output_a_oe = st.oe[0];
    assign pwm_output_b_oe = st.oe[1];

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    cbc_flag_set_a: assert property (
        cbc_event |=> cbc_flag_reg && cbc_latch_reg)
        else $error("cycle trip did not set flag and latch");
    cbc_release_a: assert property (
        cbc_latch_reg && at_zero && !cbc_event |=> !cbc_latch_reg)
        else $error("cycle trip not released at zero");
    cbc_hold_a: assert property (
        cbc_latch_reg && !at_zero |=> cbc_latch_reg)
        else $error("cycle trip released away from zero");
    cbc_sticky_a: assert property (
        cbc_flag_reg && !clr_cbc |=> cbc_flag_reg)
        else $error("cycle flag dropped without clear");
    cbc_reset_again_a: assert property (
        clr_cbc && cbc_live |=> cbc_flag_reg)
        else $error("cycle flag not set again while trip persists");
    single_trip_set_a: assert property (
        single_trip_event |=> single_trip_latch_reg ##1 (single_trip_latch_reg || $past(clr_ost)))
        else $error("single trip not latched");
    single_trip_hold_a: assert property (
        single_trip_latch_reg && !clr_ost |=> single_trip_latch_reg)
        else $error("single trip released without clear");
    force_low_a: assert property (
        st.trip_active && st.act[0] == pwm_out_pkg::ACT_LOW
        |-> !pwm_output_a && pwm_output_a_oe)
        else $error("output a not forced low");
    hiz_b_a: assert property (
        st.trip_active && st.act[1] == pwm_out_pkg::ACT_HIZ |-> !pwm_output_b_oe)
        else $error("output b not released to high impedance");
    async_trip_a: assert property (
        (cbc_live || single_trip_live) |-> st.trip_active)
        else $error("live fault not forcing outputs");
    bypass_a: assert property (
        !st.trip_active |-> pwm_output_a == st.chopped[0] && pwm_output_b_oe)
        else $error("untripped outputs not passed through");
    locked_write_a: assert property (
        wr && !prot_ok |=> $stable(sel_reg) && $stable(act_reg) && $stable(inten_reg))
        else $error("trip register changed while locked");
    irq_single_a: assert property (
        fault_interrupt_request |=> !fault_interrupt_request)
        else $error("interrupt longer than one cycle");
    irq_cause_a: assert property (
        cbc_event && inten_reg[pwm_out_pkg::FLG_CBC] && !int_flag_reg
        |=> fault_interrupt_request && int_flag_reg)
        else $error("enabled cycle trip gave no interrupt");
    chop_bypass_a: assert property (
        !st.enable |-> st.chopped == st.pwm_raw)
        else $error("disabled chopper altered the inputs");
    first_pulse_a: assert property (
        $rose(st.pwm_raw[0]) && st.enable && st.width == 4'h0
        |-> (st.chopped[0] || !st.pwm_raw[0] || !st.enable) [*8])
        else $error("first pulse shorter than eight clocks");
    high_b_a: assert property (
        st.trip_active && st.act[1] == pwm_out_pkg::ACT_HIGH |-> pwm_output_b)
        else $error("output b not high");
    keep_a_a: assert property (
        st.trip_active && st.act[0] == pwm_out_pkg::ACT_KEEP |-> pwm_output_a == st.chopped[0])
        else $error("output a changed by keep");
    single_trip_irq_a: assert property (
        single_trip_event && inten_reg[pwm_out_pkg::FLG_OST] && !int_flag_reg
        |=> fault_interrupt_request)
        else $error("no single trip interrupt");
    int_hold_a: assert property (
        int_flag_reg && !clr_int |=> int_flag_reg)
        else $error("global flag dropped");
    zero_keep_a: assert property (
        cbc_latch_reg && at_zero && cbc_event |=> cbc_latch_reg)
        else $error("cycle trip released early");

    cbc_cycle_c: cover property (cbc_latch_reg ##1 !cbc_latch_reg);
    single_trip_clear_c: cover property (single_trip_latch_reg ##1 clr_ost ##1 !single_trip_latch_reg);
    irq_c: cover property (fault_interrupt_request);
    chop_c: cover property ($rose(st.pwm_raw[1]) && st.enable);
endmodule

// >>> fault_src.sv
`timescale 1ns/100ps
// Fault sources and gate drivers on the far side of the output pair
module fault_src (
    input wire logic pclk,
    input wire logic [5:0] trip_mask,
    input wire logic out_a,
    input wire logic oe_a,
    input wire logic out_b,
    input wire logic oe_b,
    output logic [5:0] fault_n,
    output logic gate_a,
    output logic gate_b
);
    logic [5:0] stretch_reg = 6'h00;
    // A dropped fault stays low one more clock
    always @(posedge pclk) begin
        stretch_reg <= trip_mask;
    end
    // Idle lines pulled up; a fault pulls low
    assign fault_n = ~(trip_mask | stretch_reg);
    // Gate inputs pulled down while a pin floats
    assign gate_a = oe_a ? out_a : 1'b0;
    assign gate_b = oe_b ? out_b : 1'b0;
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, gate_a, gate_b;
    logic pwm_in_a, pwm_in_b, pwm_output_a, pwm_output_a_oe, pwm_output_b, pwm_output_b_oe;
    logic fault_interrupt_request;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, w;
    logic [5:0] trip_mask, fault_input_n;
    logic [15:0] time_base_counter;
    logic [2:0] f, d;
    int mismatches, n_checks, i, k, hits, len, hi;

    // Device and far side
    pwm_chopper_and_trip_zone #(.ADDR_W(8)) pwm_chopper_and_trip_zone_i (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b), .fault_input_n(fault_input_n),
        .time_base_counter(time_base_counter), .pwm_output_a(pwm_output_a),
        .pwm_output_a_oe(pwm_output_a_oe), .pwm_output_b(pwm_output_b),
        .pwm_output_b_oe(pwm_output_b_oe), .fault_interrupt_request(fault_interrupt_request));
    fault_src fault_src_i (.pclk(pclk), .trip_mask(trip_mask), .out_a(pwm_output_a),
        .oe_a(pwm_output_a_oe), .out_b(pwm_output_b), .oe_b(pwm_output_b_oe),
        .fault_n(fault_input_n), .gate_a(gate_a), .gate_b(gate_b));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Watchdog
    initial begin
        #100000;
        mismatches++;
        results();
    end

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; result left in rd and err
    task automatic apb(input logic wr, input int idx, input logic [15:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= 8'(idx * pwm_out_pkg::REG_BYTES);
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Expected {enable, gate level} for an action code
    function automatic logic [1:0] exp_pin(input logic [1:0] c, input logic x);
        case (c)
            pwm_out_pkg::ACT_HIZ: exp_pin = 2'b00;
            pwm_out_pkg::ACT_HIGH: exp_pin = 2'b11;
            pwm_out_pkg::ACT_LOW: exp_pin = 2'b10;
            default: exp_pin = {1'b1, x};
        endcase
    endfunction

    task automatic look(input logic [1:0] ea, input logic [1:0] eb);
        #1;
        check({pwm_output_a_oe, gate_a}, ea);
        check({pwm_output_b_oe, gate_b}, eb);
        @(posedge pclk);
    endtask

    task automatic zero_pulse;
        time_base_counter <= 16'h0000;
        @(posedge pclk);
        time_base_counter <= 16'h0005;
    endtask

    task automatic irq_count(input int n);
        hits = 0;
        repeat (n) begin
            #1;
            if (fault_interrupt_request === 1'b1) hits++;
            @(posedge pclk);
        end
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, pwm_in_a, pwm_in_b} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h3;
        trip_mask = 6'h00;
        time_base_counter = 16'h0005;
        void'($urandom(34));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, unmapped holes, bypass
        for (k = pwm_out_pkg::IDX_SEL; k <= pwm_out_pkg::IDX_UNLOCK; k++) begin
            apb(1'b0, k, 16'h0000);
            check(rd, 32'h0);
        end
        apb(1'b0, 'h10, 16'h0000);
        check(err, 1'b1);
        for (k = 0; k < 8; k++) begin
            pwm_in_a <= 1'($urandom);
            pwm_in_b <= 1'($urandom);
            repeat (2) @(posedge pclk);
            look({1'b1, pwm_in_a}, {1'b1, pwm_in_b});
        end
        // Locked writes ignored, then unlock
        apb(1'b1, pwm_out_pkg::IDX_SEL, 16'h3f3f);
        apb(1'b0, pwm_out_pkg::IDX_SEL, 16'h0000);
        check(rd, 32'h0);
        apb(1'b1, pwm_out_pkg::IDX_UNLOCK, 16'h0001);
        // Cycle trip on a random input: A low, B high
        i = $urandom % 6;
        apb(1'b1, pwm_out_pkg::IDX_SEL, 16'h0001 << i);
        apb(1'b0, pwm_out_pkg::IDX_SEL, 16'h0000);
        check(rd, 32'h1 << i);
        apb(1'b1, pwm_out_pkg::IDX_ACT, 16'h0006);
        apb(1'b1, pwm_out_pkg::IDX_INTEN, 16'h0002);
        pwm_in_a <= 1'b1;
        pwm_in_b <= 1'b0;
        repeat (2) @(posedge pclk);
        trip_mask <= 6'h01 << i;
        look(2'b10, 2'b11);
        irq_count(4);
        check(hits, 1);
        zero_pulse();
        look(2'b10, 2'b11);
        trip_mask <= 6'h00;
        repeat (3) @(posedge pclk);
        look(2'b10, 2'b11);
        zero_pulse();
        look(2'b11, 2'b10);
        apb(1'b0, pwm_out_pkg::IDX_FLG, 16'h0000);
        check(rd, 32'h3);
        trip_mask <= 6'h01 << i;
        irq_count(4);
        check(hits, 0);
        apb(1'b1, pwm_out_pkg::IDX_CLR, 16'h0002);
        apb(1'b0, pwm_out_pkg::IDX_FLG, 16'h0000);
        check(rd & 32'h2, 32'h2);
        trip_mask <= 6'h00;
        repeat (3) @(posedge pclk);
        apb(1'b1, pwm_out_pkg::IDX_CLR, 16'h0003);
        zero_pulse();
        look(2'b11, 2'b10);
        apb(1'b0, pwm_out_pkg::IDX_FLG, 16'h0000);
        check(rd, 32'h0);
        // Single trip with every action code on both outputs
        for (k = 0; k < 4; k++) begin
            i = $urandom % 6;
            apb(1'b1, pwm_out_pkg::IDX_SEL, 16'h0100 << i);
            apb(1'b1, pwm_out_pkg::IDX_ACT, {12'h000, 2'(3 - k), 2'(k)});
            apb(1'b1, pwm_out_pkg::IDX_INTEN, 16'h0004);
            pwm_in_a <= 1'($urandom);
            pwm_in_b <= 1'($urandom);
            repeat (2) @(posedge pclk);
            trip_mask <= 6'h01 << i;
            irq_count(3);
            check(hits, 1);
            trip_mask <= 6'h00;
            repeat (3) @(posedge pclk);
            zero_pulse();
            look(exp_pin(2'(k), pwm_in_a), exp_pin(2'(3 - k), pwm_in_b));
            apb(1'b0, pwm_out_pkg::IDX_FLG, 16'h0000);
            check(rd & 32'h4, 32'h4);
            apb(1'b1, pwm_out_pkg::IDX_CLR, 16'h0005);
            look({1'b1, pwm_in_a}, {1'b1, pwm_in_b});
        end
        // Software force, then force while locked
        apb(1'b1, pwm_out_pkg::IDX_SEL, 16'h0000);
        apb(1'b1, pwm_out_pkg::IDX_ACT, 16'h000a);
        pwm_in_a <= 1'b1;
        pwm_in_b <= 1'b1;
        apb(1'b1, pwm_out_pkg::IDX_FRC, 16'h0004);
        look(2'b10, 2'b10);
        apb(1'b1, pwm_out_pkg::IDX_FRC, 16'h0002);
        apb(1'b0, pwm_out_pkg::IDX_FLG, 16'h0000);
        check(rd, 32'h7);
        apb(1'b1, pwm_out_pkg::IDX_CLR, 16'h0007);
        zero_pulse();
        look(2'b11, 2'b11);
        apb(1'b1, pwm_out_pkg::IDX_UNLOCK, 16'h0000);
        apb(1'b1, pwm_out_pkg::IDX_FRC, 16'h0004);
        look(2'b11, 2'b11);
        // Chopper: first pulse length and carrier duty
        for (k = 0; k < 3; k++) begin
            {f, w, d} = (k == 0) ? 10'h387 : {3'($urandom % 4), 4'($urandom), 3'($urandom)};
            hi = ((d == 3'h7) ? 7 : d + 1) * (f + 1);
            len = 8 * (w + 1);
            {pwm_in_a, pwm_in_b} <= 2'b00;
            apb(1'b1, pwm_out_pkg::IDX_CHOP, {5'h00, d, f, w, 1'b1});
            repeat (4) @(posedge pclk);
            {pwm_in_a, pwm_in_b} <= 2'b11;
            i = 0;
            #1;
            while (i < 6 && gate_a !== 1'b1) begin
                @(posedge pclk);
                #1;
                i++;
            end
            i = 0;
            while (i < 300 && gate_a === 1'b1) begin
                @(posedge pclk);
                #1;
                i++;
            end
            check(i >= len && i <= len + hi, 1'b1);
            irq_count(0);
            repeat (16 * (f + 1)) begin
                if (gate_a === 1'b1) hits++;
                @(posedge pclk);
                #1;
            end
            check(hits, 2 * hi);
            @(posedge pclk);
        end
        results();
    end
endmodule
